/* File: hw/gas_avg_pkg.sv */
// constants and types shared by the gas moving-average unit
// Behaviour
// - average three corrected channels plus oxygen separately
// - period 1-59 minutes or 1-4 hours
// - every channel period defaults to one hour
// - changed period restarts only that channel
// - reset input clears all averages together
// - held reset keeps averages at zero; release restarts averaging
// - one new sample every 30 seconds
// - each interval outputs average over latest period
// - after reset past samples count as zero
package gas_avg_pkg;

  // =====================================================
  // sizes
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int SAMPLE_W = 16;
  localparam int DEPTH_MAX = 480;
  localparam int PTR_W = 9;
  localparam int SUM_W = 25;
  localparam int CNT_W = 5;

  // =====================================================
  // period limits
  localparam logic [5:0] MIN_LO = 6'h01;
  localparam logic [5:0] MIN_HI = 6'h3B;
  localparam logic [5:0] HOUR_LO = 6'h01;
  localparam logic [5:0] HOUR_HI = 6'h04;
  localparam logic [PTR_W-1:0] SAMPLES_PER_MIN = 9'h002;
  localparam logic [PTR_W-1:0] SAMPLES_PER_HOUR = 9'h078;

  // =====================================================
  // timing
  localparam longint CLK_HZ = 200_000_000;
  localparam longint SAMPLE_SEC = 30;
  localparam int TICK_W = 33;
  localparam longint SAMPLE_CYC = CLK_HZ * SAMPLE_SEC;

  // =====================================================
  // types
  typedef struct packed {
    logic in_hours;
    logic [5:0] count;
  } period_t;

  localparam period_t PERIOD_RST = '{in_hours: 1'b1, count: 6'h01};

  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
  } chan_vec_t;

  typedef struct packed {
    logic we;
    logic [CH_W-1:0] ch;
    period_t period;
  } cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_UPD = 5'b00010,
    ST_LOAD = 5'b00100,
    ST_DIV = 5'b01000,
    ST_NEXT = 5'b10000
  } state_t;

endpackage : gas_avg_pkg

/* File: hw/gas_moving_average.sv */
// moving-average unit for oxygen-corrected and oxygen channels
`timescale 1ns/10ps
module gas_moving_average #(
  parameter logic [gas_avg_pkg::TICK_W-1:0] SAMPLE_CYCLES =
    gas_avg_pkg::TICK_W'(gas_avg_pkg::SAMPLE_CYC)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire gas_avg_pkg::chan_vec_t i_sample,
  input wire logic i_avg_reset,
  input wire gas_avg_pkg::cfg_t i_cfg,
  output gas_avg_pkg::chan_vec_t o_avg,
  output logic o_avg_valid
);
  import gas_avg_pkg::*;

  // =====================================================
  // helpers
  function automatic logic [PTR_W-1:0] depth_of(input period_t p);
    logic [PTR_W-1:0] cnt;
    cnt = {3'h0, p.count};
    if (p.in_hours) begin
      depth_of = PTR_W'(cnt * SAMPLES_PER_HOUR);
    end else begin
      depth_of = PTR_W'(cnt * SAMPLES_PER_MIN);
    end
  endfunction : depth_of

  state_t state_ff;
  logic [TICK_W-1:0] tick_ff;
  logic tick;
  logic [CH_W-1:0] cur_ff;
  chan_vec_t samp_ff;
  chan_vec_t work_ff;
  logic [SUM_W-1:0] quo_ff;
  logic [PTR_W:0] rem_ff;
  logic [CNT_W-1:0] bit_ff;
  logic [SAMPLE_W-1:0] mem [NUM_CH][DEPTH_MAX];
  period_t period_ff [NUM_CH];
  logic [PTR_W-1:0] ptr_ff [NUM_CH];
  logic [PTR_W-1:0] fill_ff [NUM_CH];
  logic [SUM_W-1:0] sum_ff [NUM_CH];
  logic [PTR_W-1:0] cur_depth;
  logic cfg_ok;
  logic [PTR_W:0] trial;
  logic [PTR_W:0] nxt_rem;
  logic nxt_bit;

  // =====================================================
  // configuration check
  always_comb begin
    if (i_cfg.period.in_hours) begin
      cfg_ok = i_cfg.period.count >= HOUR_LO && i_cfg.period.count <= HOUR_HI;
    end else begin
      cfg_ok = i_cfg.period.count >= MIN_LO && i_cfg.period.count <= MIN_HI;
    end
    cfg_ok = cfg_ok && i_cfg.we;
  end

  // =====================================================
  // 30 s sample timer
  // held at zero during the average reset so the first window starts at release
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tick_ff <= '0;
    end else if (i_ce) begin
      if (i_avg_reset || tick_ff == SAMPLE_CYCLES - 1'b1) begin
        tick_ff <= '0;
      end else begin
        tick_ff <= tick_ff + 1'b1;
      end
    end
  end
  assign tick = (tick_ff == SAMPLE_CYCLES - 1'b1) && !i_avg_reset;

  // =====================================================
  // per-channel window bookkeeping
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      logic changed;
      logic full;
      logic [PTR_W-1:0] depth;
      logic [SAMPLE_W-1:0] old_val;
      assign depth = depth_of(period_ff[g]);
      assign full = (fill_ff[g] == depth);
      assign changed = cfg_ok && i_cfg.ch == CH_W'(g) && i_cfg.period != period_ff[g];
      // unfilled slots read as zero, so no sweep of the buffer is needed on clear
      assign old_val = full ? mem[g][ptr_ff[g]] : '0;
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          period_ff[g] <= PERIOD_RST;
        end else if (i_ce && changed) begin
          period_ff[g] <= i_cfg.period;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          ptr_ff[g] <= '0;
          fill_ff[g] <= '0;
          sum_ff[g] <= '0;
        end else if (i_ce) begin
          if (i_avg_reset || changed) begin
            ptr_ff[g] <= '0;
            fill_ff[g] <= '0;
            sum_ff[g] <= '0;
          end else if (state_ff == ST_UPD && cur_ff == CH_W'(g)) begin
            sum_ff[g] <= sum_ff[g] + SUM_W'(samp_ff.ch[g]) - SUM_W'(old_val);
            ptr_ff[g] <= (ptr_ff[g] == depth - 1'b1) ? '0 : ptr_ff[g] + 1'b1;
            if (!full) begin
              fill_ff[g] <= fill_ff[g] + 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // =====================================================
  // sample storage
  always_ff @(posedge i_clk) begin
    if (i_ce && !i_avg_reset && state_ff == ST_UPD) begin
      mem[cur_ff][ptr_ff[cur_ff]] <= samp_ff.ch[cur_ff];
    end
  end

  // =====================================================
  // divider step: sum over window length
  // restoring divide, one bit a cycle: slow but tiny next to the 30 s tick
  assign cur_depth = depth_of(period_ff[cur_ff]);
  always_comb begin
    trial = {rem_ff[PTR_W-1:0], quo_ff[SUM_W-1]};
    nxt_bit = trial >= {1'b0, cur_depth};
    nxt_rem = nxt_bit ? trial - {1'b0, cur_depth} : trial;
  end

  // =====================================================
  // sequencer
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      samp_ff <= '0;
      work_ff <= '0;
      quo_ff <= '0;
      rem_ff <= '0;
      bit_ff <= '0;
    end else if (i_ce) begin
      if (i_avg_reset) begin
        state_ff <= ST_IDLE;
        work_ff <= '0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (tick) begin
              samp_ff <= i_sample;
              cur_ff <= '0;
              state_ff <= ST_UPD;
            end
          end
          ST_UPD: begin
            state_ff <= ST_LOAD;
          end
          ST_LOAD: begin
            quo_ff <= sum_ff[cur_ff];
            rem_ff <= '0;
            bit_ff <= CNT_W'(SUM_W - 1);
            state_ff <= ST_DIV;
          end
          ST_DIV: begin
            rem_ff <= nxt_rem;
            quo_ff <= {quo_ff[SUM_W-2:0], nxt_bit};
            bit_ff <= bit_ff - 1'b1;
            if (bit_ff == '0) begin
              state_ff <= ST_NEXT;
            end
          end
          ST_NEXT: begin
            work_ff.ch[cur_ff] <= quo_ff[SAMPLE_W-1:0];
            if (cur_ff == CH_W'(NUM_CH - 1)) begin
              state_ff <= ST_IDLE;
            end else begin
              cur_ff <= cur_ff + 1'b1;
              state_ff <= ST_UPD;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // =====================================================
  // outputs
  // all channels publish together once the last quotient lands
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avg <= '0;
    end else if (i_ce) begin
      if (i_avg_reset) begin
        o_avg <= '0;
      end else if (state_ff == ST_NEXT && cur_ff == CH_W'(NUM_CH - 1)) begin
        o_avg <= work_ff;
        o_avg.ch[NUM_CH-1] <= quo_ff[SAMPLE_W-1:0];
      end
    end
  end

  // =====================================================
  // publish strobe
  // one cycle wide, so a consumer may latch o_avg on it without edge detection
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avg_valid <= 1'b0;
    end else if (i_ce) begin
      o_avg_valid <= !i_avg_reset && state_ff == ST_NEXT && cur_ff == CH_W'(NUM_CH - 1);
    end
  end

endmodule : gas_moving_average

/* File: verification/gas_moving_average_monitor.sv */
// port checker of the moving-average unit
`timescale 1ns/10ps
module gas_moving_average_monitor
  import gas_avg_pkg::*;
#(
  parameter logic [TICK_W-1:0] SAMPLE_CYCLES = TICK_W'(SAMPLE_CYC)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire gas_avg_pkg::chan_vec_t i_sample,
  input wire logic i_avg_reset,
  input wire gas_avg_pkg::cfg_t i_cfg,
  input wire gas_avg_pkg::chan_vec_t o_avg,
  input wire logic o_avg_valid
);
  // =====================================================
  // cycles since last publish or restart
  logic [TICK_W-1:0] gap_ff;
  always_ff @(posedge i_clk) begin
    if (i_reset || i_avg_reset || o_avg_valid) begin
      gap_ff <= '0;
    end else if (i_ce && gap_ff != '1) begin
      gap_ff <= gap_ff + 1'b1;
    end
  end
  // =====================================================
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_pulse;
    o_avg_valid ##1 !o_avg_valid;
  endsequence
  a_valid_pulse: assert property (o_avg_valid |-> s_pulse)
    else $error("publish pulse too long");
  a_avg_clear: assert property (i_avg_reset && i_ce |=> o_avg == '0)
    else $error("average not cleared");
  a_clear_quiet: assert property (i_avg_reset && i_ce |=> !o_avg_valid)
    else $error("publish during average reset");
  a_release_zero: assert property ($fell(i_avg_reset) |-> o_avg == '0)
    else $error("average moved while reset held");
  a_change_cause: assert property ($changed(o_avg) |->
    o_avg_valid || $past(i_avg_reset))
    else $error("average changed without publish");
  a_tick_early: assert property (o_avg_valid |-> gap_ff >= SAMPLE_CYCLES - 2)
    else $error("publish too early");
  a_tick_late: assert property (gap_ff <= SAMPLE_CYCLES + 120)
    else $error("publish overdue");
  sequence s_cfg_quiet;
    i_cfg.we && !i_avg_reset ##1 !o_avg_valid;
  endsequence
  a_cfg_silent: assert property (s_cfg_quiet |-> $stable(o_avg))
    else $error("period write moved average");
endmodule : gas_moving_average_monitor

/* File: verification/avg_reset_contact.sv */
// model of the external average-reset contact
`timescale 1ns/10ps
module avg_reset_contact #(
  parameter int HOLD_CYC = 300
) (
  input wire logic i_clk,
  input wire logic i_go,
  output logic o_contact
);
  // =====================================================
  // contact hold
  // hold is shortened to cycles, but spans a sample tick
  int cnt_ff = 0;
  always @(posedge i_clk) begin
    if (i_go && cnt_ff == 0) begin
      cnt_ff <= HOLD_CYC;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  assign o_contact = (cnt_ff != 0);
endmodule : avg_reset_contact

/* File: verification/gas_moving_average_tb.sv */
// self-checking bench of the moving-average unit
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module gas_moving_average_tb;
  import gas_avg_pkg::*;
  // =====================================================
  // stimulus and instances
  localparam logic [TICK_W-1:0] SIM_CYC = 33'h0_0000_00C8;
  typedef struct {logic [15:0] s; logic [15:0] e0; logic [15:0] e1;} row_t;
  row_t rows [3] = '{'{16'h0064, 16'h0000, 16'h0032}, '{16'h00C8, 16'h0002, 16'h0096},
    '{16'h00F0, 16'h0004, 16'h00DC}};
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_ce = 1'b1;
  chan_vec_t i_sample = '0;
  cfg_t i_cfg = '0;
  logic go = 1'b0;
  logic contact;
  chan_vec_t o_avg;
  logic o_avg_valid;
  int n_fail = 0;
  int num_checks = 0;
  gas_moving_average #(.SAMPLE_CYCLES(SIM_CYC)) i_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_ce(i_ce), .i_sample(i_sample), .i_avg_reset(contact), .i_cfg(i_cfg), .o_avg(o_avg),
    .o_avg_valid(o_avg_valid));
  avg_reset_contact #(.HOLD_CYC(300)) i_contact (.i_clk(i_clk), .i_go(go), .o_contact(contact));
  always #2.5 i_clk = ~i_clk;
  // =====================================================
  // tasks
  task automatic set_period(input logic [1:0] ch, input logic hrs, input logic [5:0] cnt);
    @(negedge i_clk);
    i_cfg = '{we: 1'b1, ch: ch, period: '{in_hours: hrs, count: cnt}};
    @(negedge i_clk);
    i_cfg.we = 1'b0;
  endtask : set_period
  // the wait covers a restart: one full interval plus the divide sweep
  task automatic sample(input logic [15:0] s, input logic [15:0] e0, input logic [15:0] e1);
    int k;
    k = 0;
    i_sample = {4{s}};
    do begin
      @(negedge i_clk);
      k++;
    end while (o_avg_valid !== 1'b1 && k < 500);
    `CHK(o_avg_valid, 1'b1)
    `CHK(o_avg.ch[0], e0)
    `CHK(o_avg.ch[3], e0)
    `CHK(o_avg.ch[2], e0)
    `CHK(o_avg.ch[1], e1)
  endtask : sample
  task automatic complete_run;
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // =====================================================
  // tests
  initial begin
    repeat (4) @(negedge i_clk);
    `CHK(o_avg, 64'h0)
    `CHK(o_avg_valid, 1'b0)
    i_reset = 1'b0;
    set_period(2'h1, 1'b0, 6'h01);
    foreach (rows[i]) begin
      sample(rows[i].s, rows[i].e0, rows[i].e1);
    end
    set_period(2'h1, 1'b0, 6'h02);
    sample(16'h0078, 16'h0005, 16'h001E);
    set_period(2'h1, 1'b0, 6'h00);
    set_period(2'h1, 1'b0, 6'h3C);
    set_period(2'h1, 1'b1, 6'h05);
    sample(16'h0078, 16'h0006, 16'h003C);
    @(negedge i_clk);
    go = 1'b1;
    @(negedge i_clk);
    go = 1'b0;
    repeat (290) @(negedge i_clk);
    `CHK(o_avg, 64'h0)
    sample(16'h00F0, 16'h0002, 16'h003C);
    set_period(2'h1, 1'b1, 6'h04);
    sample(16'h01E0, 16'h0006, 16'h0001);
    set_period(2'h1, 1'b1, 6'h04);
    sample(16'h01E0, 16'h000A, 16'h0002);
    i_sample = {4{16'h0F00}};
    @(negedge i_clk);
    i_ce = 1'b0;
    repeat (250) @(negedge i_clk);
    `CHK(o_avg.ch[0], 16'h000A)
    `CHK(o_avg_valid, 1'b0)
    i_ce = 1'b1;
    sample(16'h0F00, 16'h002A, 16'h000A);
    complete_run();
  end
  initial begin
    #40000;
    n_fail++;
    complete_run();
  end
endmodule : gas_moving_average_tb
bind gas_moving_average gas_moving_average_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_mon (
  .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_sample(i_sample), .i_avg_reset(i_avg_reset),
  .i_cfg(i_cfg), .o_avg(o_avg), .o_avg_valid(o_avg_valid));
